//--- src/hpe_map.svh
// Purpose: Constants for the host port and event pin block.
// Assumes: 10 MHz core clock, one cycle every 100 ns.
// Notes: Lockout delay count follows from the minimum microsecond limit and the core clock rate.
`ifndef HPE_MAP_SVH
`define HPE_MAP_SVH
`define HPE_CLK_MHZ 10
`define HPE_LOCK_MIN_US 30
`define HPE_LOCK_MAX_US 63
`define HPE_LOCK_CYC (`HPE_LOCK_MIN_US * `HPE_CLK_MHZ)
`define HPE_NSRC 4
`define HPE_SRC_PER 0
`define HPE_SRC_ALM 1
`define HPE_SRC_TMR 2
`define HPE_SRC_PWR 3
`define HPE_MFO_INT 2'h0
`define HPE_MFO_OSC 2'h1
`define HPE_MFO_TM0 2'h2
`define HPE_XSEL_OFF 2'h3
`endif

//--- src/hpe_pkg.sv
// Purpose: Types for the host port and event pin block.
// Assumes: Constants come from hpe_map.svh.
// Notes: Pin drive groups travel as one struct.
package hpe_pkg;
  typedef enum logic [2:0] {
    HPE_IDLE = 3'b001,
    HPE_WRITE = 3'b010,
    HPE_READ = 3'b100
  } hpe_bus_st_t;
  typedef struct packed {
    logic o;
    logic oe;
  } hpe_pin_t;
  typedef struct packed {
    logic pol_high;
    logic push_pull;
  } hpe_drive_t;
endpackage

//--- src/hpe_host_port.sv
// Purpose: Host port strobe decode, power-fail lockout, interrupt routing and event pins.
// Assumes: All inputs except i_rst synchronous to i_core_clk.
// Notes: Register storage lives outside; this block frames accesses and drives pins.
`timescale 1ns/10ps
`include "hpe_map.svh"

// Overview of operation
// R1: Four interrupt sources: periodic, alarm, timer, power.
// R2: Each source has a mask and status bit.
// R3: Dedicated and multi-function outputs route any source.
// R4: Multi-function output may carry oscillator or timer0.
// R5: Access only with select low plus strobe low.
// R6: Lockout ignores strobes; ongoing access completes.
// R7: Five address lines select the location.
// R8: Address lines ignored once locked out.
// R9: Multi-function output: programmable polarity and drive.
// R10: Battery operation forces outputs open drain.
// R11: Interrupt asserts on enabled event or power fail; code asserts it on enabled status bits only, not on power fail.
// R12: Interrupt output: programmable polarity and drive.
// R13: Interrupt is a level; cleared by writing one.
// R14: Eight-bit bidirectional data bus.
// R15: Power fail without write floats data bus; code still drives it for a read past its first cycle.
// R16: Lockout 30 to 63 us after power fail.
// R17: Single supply systems tie power fail high.
// R18: External timer clock feeds selected timers.
// R19: Modes 0-2: gate is active-low count enable.
// R20: Mode 3: gate rising edge triggers timer.
// R21: Timer1 output: programmable polarity and drive.
// R22: Oscillator runs only with valid crystal select.
// R23: Write ends when select or strobe rises.
module hpe_host_port
  import hpe_pkg::*;
#(
  parameter int LOCK_CYC = `HPE_LOCK_CYC,
  parameter int ADDR_W = 5,
  parameter int DATA_W = 8
) (
  input wire logic i_core_clk, // Core clock, 10 MHz.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic i_chip_select_n, // Host select, active low.
  input wire logic i_read_n, // Host read strobe, active low.
  input wire logic i_write_n, // Host write strobe, active low.
  input wire logic [ADDR_W-1:0] i_register_select_lines, // Register address.
  input wire logic [DATA_W-1:0] i_host_data_bus, // Data bus pin input.
  input wire logic [DATA_W-1:0] i_read_data, // Read data from register file.
  input wire logic i_power_fail_input_n, // Power fail, active low.
  input wire logic i_battery_mode, // Running from backup supply.
  input wire logic i_lockout_delay_en, // Programmed lockout delay in use.
  input wire logic i_lockout_delay_done, // Programmed delay expired.
  input wire logic [`HPE_NSRC-1:0] i_event_pulse, // Source events.
  input wire logic [`HPE_NSRC-1:0] i_int_mask, // Source enables.
  input wire logic [`HPE_NSRC-1:0] i_route_mfo, // Sources routed to MULTI_FUNCTION_OUTPUT path.
  input wire logic [1:0] i_mfo_sel, // Multi-function output selection.
  input wire hpe_drive_t i_interrupt_output_drive, // Interrupt output polarity and drive.
  input wire hpe_drive_t i_mfo_drive, // MULTI_FUNCTION_OUTPUT polarity and drive.
  input wire hpe_drive_t i_t1_drive, // Timer1 output polarity and drive.
  input wire logic [1:0] i_crystal_select, // Crystal select bits.
  input wire logic i_power_present, // Supply present.
  input wire logic i_crystal_input, // Oscillator input level.
  input wire logic i_timer_ext_clk, // External timer clock pin.
  input wire logic [1:0] i_timer_ext_sel, // Timer uses external clock.
  input wire logic [1:0] i_timer_mode0, // Timer0 mode.
  input wire logic [1:0] i_timer_mode1, // Timer1 mode.
  input wire logic i_timer0_gate, // Timer0 gate pin.
  input wire logic i_timer1_gate, // Timer1 gate pin.
  input wire logic i_timer0_out, // Timer0 internal output.
  input wire logic i_timer1_out, // Timer1 internal output.
  output logic [DATA_W-1:0] o_host_data_bus, // Data bus drive.
  output logic o_host_data_oe, // Data bus output enable.
  output logic o_reg_wr, // Write pulse to register file.
  output logic o_reg_rd, // Read strobe level to register file.
  output logic [ADDR_W-1:0] o_reg_addr, // Latched address.
  output logic [DATA_W-1:0] o_reg_wdata, // Captured write data.
  output logic o_locked, // Host lockout active.
  output logic [`HPE_NSRC-1:0] o_int_status, // Sticky status bits.
  output hpe_pin_t o_interrupt_output, // Dedicated interrupt pin.
  output hpe_pin_t o_multi_function_output, // Multi-function pin.
  output hpe_pin_t o_timer1_output, // Timer1 pin.
  output logic o_crystal_output, // Oscillator drive.
  output logic [1:0] o_timer_ext_tick, // External clock rising edge per timer.
  output logic [1:0] o_timer_count_en, // Count enable per timer.
  output logic [1:0] o_timer_trigger // Trigger pulse per timer.
);

  initial begin
    if (ADDR_W != 5 || DATA_W != 8 || LOCK_CYC < 1) begin
      $error("hpe_host_port: unsupported parameter values");
    end
  end

  localparam int LW = $clog2(LOCK_CYC + 1);

  typedef struct packed {
    hpe_bus_st_t st;
    logic [LW-1:0] lock_cnt;
    logic locked;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic data_oe;
    logic wr;
    logic [`HPE_NSRC-1:0] status;
    hpe_pin_t interrupt_output;
    hpe_pin_t multi_function_output;
    hpe_pin_t t1;
    logic xout;
    logic tck_prev;
    logic [1:0] gate_prev;
    logic [1:0] tick;
    logic [1:0] cen;
    logic [1:0] trig;
  } hpe_state_t;

  hpe_state_t s_q;
  hpe_state_t s_d;

  // Polarity then drive type; battery forces open drain, which only pulls to active low level.
  function automatic hpe_pin_t drive_pin(input logic act, input hpe_drive_t dr, input logic batt);
    hpe_pin_t p;
    logic lvl;
    lvl = dr.pol_high ? act : ~act;
    if (dr.push_pull && !batt) begin
      p.o = lvl;
      p.oe = 1'b1;
    end else begin
      p.o = 1'b0;
      p.oe = ~lvl;
    end
    return p;
  endfunction

  function automatic logic gate_en(input logic [1:0] mode, input logic g);
    return (mode != 2'h3) && !g;
  endfunction

  logic sel_wr;
  logic sel_rd;
  logic [`HPE_NSRC-1:0] clr_bits;

  // ============================================================
  // Host access and lockout
  // ============================================================
  always_comb begin
    s_d = s_q;
    sel_wr = !i_chip_select_n && !i_write_n; // [R5]
    sel_rd = !i_chip_select_n && !i_read_n; // [R5]
    clr_bits = '0;
    s_d.wr = 1'b0;
    // Lockout timer counts the minimum delay; a programmed delay overrides it.
    // The count runs to the full limit, so power fail has been low for at least the minimum first.
    if (i_power_fail_input_n) begin
      s_d.lock_cnt = '0;
      s_d.locked = 1'b0;
    end else if (i_battery_mode && !s_q.locked) begin
      if (i_lockout_delay_en) begin
        s_d.locked = i_lockout_delay_done; // [R16]
      end else if (s_q.lock_cnt == LW'(LOCK_CYC)) begin
        s_d.locked = 1'b1; // [R16]
      end else begin
        s_d.lock_cnt = s_q.lock_cnt + LW'(1); // [R16]
      end
    end
    case (s_q.st)
      HPE_IDLE: begin
        // Lockout blocks only new cycles so an access already begun completes.
        if (!s_q.locked && sel_wr) begin // [R6] [R8]
          s_d.st = HPE_WRITE;
          s_d.addr = i_register_select_lines; // [R7]
          s_d.wdata = i_host_data_bus; // [R14]
        end else if (!s_q.locked && sel_rd) begin // [R6] [R8]
          s_d.st = HPE_READ;
          s_d.addr = i_register_select_lines; // [R7]
        end
      end
      HPE_WRITE: begin
        // Data is taken only while the strobe is seen low; the host may change it as the strobe rises.
        if (sel_wr) begin
          s_d.wdata = i_host_data_bus; // [R14] [R23]
        end
        if (!sel_wr) begin
          s_d.wr = 1'b1; // [R23]
          s_d.st = HPE_IDLE;
          if (s_q.addr == '0) begin
            clr_bits = s_q.wdata[`HPE_NSRC-1:0]; // [R13]
          end
        end
      end
      HPE_READ: begin
        if (!sel_rd) begin
          s_d.st = HPE_IDLE;
        end
      end
      default: s_d.st = HPE_IDLE;
    endcase
    // A read already under way keeps its drive; an idle port leaves the bus released at power fail.
    s_d.rdata = i_read_data;
    s_d.data_oe = (s_d.st == HPE_READ) && !(!i_power_fail_input_n && s_q.st != HPE_WRITE
                  && s_q.st != HPE_READ); // [R14] [R15]
    // ============================================================
    // Interrupts and pins
    // ============================================================
    // Set wins over clear so an event in the clearing cycle is kept.
    s_d.status = (s_q.status & ~clr_bits) | i_event_pulse; // [R1] [R2] [R13]
    // A source routed to the multi-function path stays off the dedicated pin.
    s_d.interrupt_output = drive_pin(|(s_d.status & i_int_mask & ~i_route_mfo), i_interrupt_output_drive,
                         i_battery_mode); // [R3] [R11] [R12] [R10]
    case (i_mfo_sel)
      `HPE_MFO_OSC: s_d.multi_function_output = drive_pin(s_q.xout, i_mfo_drive, i_battery_mode); // [R4] [R9] [R10]
      `HPE_MFO_TM0: s_d.multi_function_output = drive_pin(i_timer0_out, i_mfo_drive, i_battery_mode); // [R4]
      default: s_d.multi_function_output = drive_pin(|(s_d.status & i_int_mask & i_route_mfo), i_mfo_drive,
                                   i_battery_mode); // [R3] [R9]
    endcase
    s_d.t1 = drive_pin(i_timer1_out, i_t1_drive, i_battery_mode); // [R21] [R10]
    // The crystal amplifier inverts, so while it runs the output is the inverse of the input.
    s_d.xout = i_power_present && (i_crystal_select != `HPE_XSEL_OFF) && !i_crystal_input; // [R22]
    s_d.tck_prev = i_timer_ext_clk;
    s_d.tick = i_timer_ext_sel & {2{i_timer_ext_clk && !s_q.tck_prev}}; // [R18]
    s_d.gate_prev = {i_timer1_gate, i_timer0_gate};
    s_d.cen = {gate_en(i_timer_mode1, i_timer1_gate), gate_en(i_timer_mode0, i_timer0_gate)}; // [R19]
    s_d.trig = {i_timer_mode1 == 2'h3 && i_timer1_gate && !s_q.gate_prev[1],
                i_timer_mode0 == 2'h3 && i_timer0_gate && !s_q.gate_prev[0]}; // [R20]
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= HPE_IDLE;
      // Gates idle high, so a gate already high at reset is not taken for a trigger edge.
      s_q.gate_prev <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_host_data_bus = s_q.rdata;
  assign o_host_data_oe = s_q.data_oe;
  assign o_reg_wr = s_q.wr;
  assign o_reg_rd = s_q.st == HPE_READ;
  assign o_reg_addr = s_q.addr;
  assign o_reg_wdata = s_q.wdata;
  assign o_locked = s_q.locked;
  assign o_int_status = s_q.status;
  assign o_interrupt_output = s_q.interrupt_output;
  assign o_multi_function_output = s_q.multi_function_output;
  assign o_timer1_output = s_q.t1;
  assign o_crystal_output = s_q.xout;
  assign o_timer_ext_tick = s_q.tick;
  assign o_timer_count_en = s_q.cen;
  assign o_timer_trigger = s_q.trig;

  // ============================================================
  // Checks
  // ============================================================
  a_lock_min: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R16]
    $rose(s_q.locked) && !i_lockout_delay_en |-> !$past(i_power_fail_input_n, LOCK_CYC))
    else $error("lockout before minimum delay");
  a_no_new_access: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R6]
    s_q.locked && s_q.st == HPE_IDLE |=> s_q.st == HPE_IDLE)
    else $error("access started during lockout");
  a_wr_end: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R23]
    s_q.st == HPE_WRITE && !sel_wr |=> s_q.wr && s_q.st == HPE_IDLE)
    else $error("write end not pulsed");
  a_wr_only: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R5]
    s_q.wr |-> $past(s_q.st) == HPE_WRITE)
    else $error("write pulse without cycle");
  a_status_sticky: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R13]
    $past(i_event_pulse[0]) |-> s_q.status[0])
    else $error("event lost");
  a_batt_od: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R10]
    $past(i_battery_mode) |-> !(s_q.t1.oe && s_q.t1.o) && !(s_q.interrupt_output.oe && s_q.interrupt_output.o))
    else $error("pin drives high in battery mode");
  a_osc_off: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R22]
    !$past(i_power_present) |-> !s_q.xout)
    else $error("oscillator runs without power");
  a_gate_en: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R19]
    $past(i_timer_mode0) != 2'h3 && !$past(i_timer0_gate) |-> s_q.cen[0])
    else $error("gate enable wrong");
  a_addr_frozen: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R8]
    s_q.locked && s_q.st == HPE_IDLE |=> $stable(s_q.addr))
    else $error("address taken during lockout");
  a_idle_no_drive: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R15]
    !i_power_fail_input_n && s_q.st == HPE_IDLE |=> !s_q.data_oe)
    else $error("data bus driven at power fail");
  a_read_take: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R5]
    s_q.st == HPE_IDLE && !s_q.locked && sel_rd && !sel_wr |=> s_q.st == HPE_READ)
    else $error("read not taken");
  a_trig_mode: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R20]
    s_q.trig[0] |-> $past(i_timer_mode0) == 2'h3)
    else $error("trigger outside trigger mode");
  a_cen_mode: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R19]
    s_q.cen[1] |-> $past(i_timer_mode1) != 2'h3 && !$past(i_timer1_gate))
    else $error("count enable without low gate");
  a_tick_sel: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R18]
    s_q.tick[1] |-> $past(i_timer_ext_sel[1]))
    else $error("tick on timer without external clock");
  a_mfo_batt_od: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R10]
    $past(i_battery_mode) |-> !(s_q.multi_function_output.oe && s_q.multi_function_output.o))
    else $error("function pin drives high in battery mode");
  c_write: cover property (@(posedge i_core_clk) s_q.wr);
  c_read: cover property (@(posedge i_core_clk) s_q.st == HPE_READ);
  c_lock: cover property (@(posedge i_core_clk) $rose(s_q.locked));
  c_trig: cover property (@(posedge i_core_clk) s_q.trig[1]);
  c_osc: cover property (@(posedge i_core_clk) s_q.xout);
endmodule

//--- verification/hpe_host_model.sv
// Purpose: Host processor model on the asynchronous byte port.
// Assumes: Its signals change at the falling clock edge.
// Notes: Between cycles the lines show inverted values, so a held value never passes.
`timescale 1ns/10ps
module hpe_host_model (
  input wire logic i_clk, // Core clock.
  output logic o_cs_n, // Select, active low.
  output logic o_rd_n, // Read strobe, active low.
  output logic o_wr_n, // Write strobe, active low.
  output logic [4:0] o_addr, // Register address.
  output logic [7:0] o_data // Write data.
);
  initial begin
    {o_cs_n, o_rd_n, o_wr_n, o_addr, o_data} = 16'hffff;
  end
  // Strobes stay low for n cycles and rise together, which ends the cycle.
  task automatic access(input logic cs, input logic wr, input logic [4:0] a, input logic [7:0] d, input int n);
    @(negedge i_clk);
    {o_addr, o_data} = {a, d};
    {o_cs_n, o_rd_n, o_wr_n} = {~cs, wr, ~wr};
    repeat (n) @(negedge i_clk);
    {o_cs_n, o_rd_n, o_wr_n, o_addr, o_data} = {3'h7, ~a, ~d};
  endtask
endmodule

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the host port and event pin block.
// Assumes: Inputs change at the falling edge; lockout count shortened to ten cycles.
// Notes: Some scenarios leave inputs that they move, such as route, t0o, t1o, mode0 and mode1, at their last values.
`timescale 1ns/10ps
`include "hpe_map.svh"
module tb_top
  import hpe_pkg::*;
;
  localparam int LCYC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, rd_n, wr_n, d_oe, reg_wr, reg_rd, locked;
  logic [4:0] addr, reg_addr;
  logic [7:0] hdata, d_dq, wdata;
  logic [7:0] rdata = 8'h5a;
  logic pf_n = 1'b1;
  logic pwr = 1'b1, xin = 1'b0, lde = 1'b0, ldd = 1'b0, xout;
  logic [1:0] xsel = `HPE_XSEL_OFF;
  logic batt = 1'b0, tck = 1'b0, g0 = 1'b1, g1 = 1'b1, t0o = 1'b0, t1o = 1'b0;
  logic [3:0] ev = 4'h0, mask = 4'hf, route = 4'h0, status;
  logic [1:0] msel = 2'h0, tsel = 2'h0, mode0 = 2'h0, mode1 = 2'h0, tick, cen, trig;
  hpe_drive_t idrv = 2'h3, mdrv = 2'h3, tdrv = 2'h3;
  hpe_pin_t interrupt_output, multi_function_output, t1p;
  int failures = 0, num_checks = 0, wr_seen = 0;
  wire logic [7:0] bus = d_oe ? d_dq : hdata;

  always #50 clk = ~clk;
  always @(negedge clk) if (reg_wr === 1'b1) wr_seen++;

  hpe_host_model i_host (.i_clk(clk), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_data(hdata));
  hpe_host_port #(.LOCK_CYC(LCYC)) i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_chip_select_n(cs_n), .i_read_n(rd_n), .i_write_n(wr_n),
    .i_register_select_lines(addr), .i_host_data_bus(bus), .i_read_data(rdata), .i_power_fail_input_n(pf_n),
    .i_battery_mode(batt), .i_lockout_delay_en(lde), .i_lockout_delay_done(ldd), .i_event_pulse(ev),
    .i_int_mask(mask), .i_route_mfo(route), .i_mfo_sel(msel), .i_interrupt_output_drive(idrv), .i_mfo_drive(mdrv),
    .i_t1_drive(tdrv), .i_crystal_select(xsel), .i_power_present(pwr), .i_crystal_input(xin),
    .i_timer_ext_clk(tck), .i_timer_ext_sel(tsel), .i_timer_mode0(mode0), .i_timer_mode1(mode1),
    .i_timer0_gate(g0), .i_timer1_gate(g1), .i_timer0_out(t0o), .i_timer1_out(t1o),
    .o_host_data_bus(d_dq), .o_host_data_oe(d_oe), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
    .o_reg_wdata(wdata), .o_locked(locked), .o_int_status(status), .o_interrupt_output(interrupt_output),
    .o_multi_function_output(multi_function_output), .o_timer1_output(t1p), .o_crystal_output(xout), .o_timer_ext_tick(tick),
    .o_timer_count_en(cen), .o_timer_trigger(trig));

  // ==========================================================================
  // Checking and closing.
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t ns: %s", $time, m);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Write pulses are counted by the monitor, so a stretched pulse shows as extra counts.
  task automatic acc(input logic cs, input logic wr, input logic [4:0] a, input logic [7:0] d, input int n,
                     input int exp_wr);
    int w;
    w = wr_seen;
    i_host.access(cs, wr, a, d, n);
    repeat (4) @(negedge clk);
    chk(wr_seen - w == exp_wr, "write pulse count");
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_port();
    acc(1'b0, 1'b1, 5'h13, 8'ha6, 2, 0);
    acc(1'b1, 1'b1, 5'h1f, 8'h5c, 3, 1);
    chk(reg_addr === 5'h1f && wdata === 8'h5c, "write address or data");
    i_host.access(1'b1, 1'b0, 5'h0b, 8'h00, 2);
    chk(d_oe === 1'b1 && reg_rd === 1'b1 && d_dq === rdata && reg_addr === 5'h0b, "read");
    repeat (2) @(negedge clk);
    chk(d_oe === 1'b0 && reg_rd === 1'b0, "read end");
  endtask
  task automatic t_irq();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      {idrv, route, ev} = {i[1], 1'b1, 4'(i[0]) << i, 4'h1 << i};
      @(negedge clk);
      ev = 4'h0;
      repeat (3) @(negedge clk);
      chk(status[i] === 1'b1 && interrupt_output.o === (idrv.pol_high ~^ !i[0]) && multi_function_output.o === i[0], "irq set");
      acc(1'b1, 1'b1, 5'h00, 8'h1 << i, 1, 1);
      chk(status[i] === 1'b0 && interrupt_output.o === !idrv.pol_high && multi_function_output.o === 1'b0, "irq clear");
    end
    mask = 4'h0;
    ev = 4'hf;
    @(negedge clk);
    ev = 4'h0;
    repeat (2) @(negedge clk);
    chk(interrupt_output.o === !idrv.pol_high && multi_function_output.o === 1'b0, "masked irq");
    acc(1'b1, 1'b1, 5'h00, 8'h0f, 1, 1);
    mask = 4'hf;
  endtask
  task automatic t_drive();
    logic lvl, dr;
    msel = `HPE_MFO_TM0;
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      {mdrv, batt, t0o} = k[3:0];
      {tdrv, t1o} = {mdrv, t0o};
      repeat (2) @(negedge clk);
      lvl = mdrv.pol_high ~^ t0o;
      dr = mdrv.push_pull & ~batt;
      chk(multi_function_output.oe === (dr | ~lvl) && (multi_function_output.oe === 1'b0 || multi_function_output.o === lvl), "function pin");
      chk(t1p.oe === (dr | ~lvl) && (t1p.oe === 1'b0 || t1p.o === lvl), "timer pin");
    end
    {batt, msel, mdrv} = {1'b0, `HPE_MFO_INT, 2'h3};
  endtask
  task automatic t_gate();
    int n;
    for (int m = 0; m < 4; m++) begin
      @(negedge clk);
      {mode0, mode1, g0, g1} = {m[1:0], m[1:0], 2'b00};
      repeat (3) @(negedge clk);
      chk(m == 3 || cen === 2'b11, "gate enable");
      {g0, g1} = 2'b11;
      n = 0;
      repeat (4) begin
        @(negedge clk);
        n += (trig[0] === 1'b1) + (trig[1] === 1'b1);
      end
      chk(n == 2 * (m == 3) && (m == 3 || cen === 2'b00), "gate trigger");
    end
  endtask
  task automatic t_aux();
    {xsel, msel, mdrv} = {2'h0, `HPE_MFO_OSC, 2'h3};
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      {pwr, xin, xsel} = {k != 2, k == 1, (k == 3) ? `HPE_XSEL_OFF : 2'h0};
      repeat (2) @(negedge clk);
      chk(xout === (k == 0) && multi_function_output.o === (k == 0), "oscillator");
    end
    {pwr, xsel, msel} = {1'b1, `HPE_XSEL_OFF, `HPE_MFO_INT};
    for (int j = 0; j < 2; j++) begin
      tsel = 2'h1 << j;
      tck = 1'b1;
      @(negedge clk);
      chk(tick === tsel, "external clock edge");
      tck = 1'b0;
      @(negedge clk);
      chk(tick === 2'h0, "external clock pulse");
    end
    tsel = 2'h0;
    {batt, lde, pf_n} = 3'b110;
    repeat (LCYC + 4) @(negedge clk);
    chk(locked === 1'b0, "programmed delay early");
    ldd = 1'b1;
    repeat (2) @(negedge clk);
    chk(locked === 1'b1, "programmed delay lockout");
    {batt, lde, ldd, pf_n} = 4'h1;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_lock();
    int n = 0;
    batt = 1'b1;
    pf_n = 1'b0;
    while (locked !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(n >= LCYC && n <= LCYC + 2 && d_oe === 1'b0, "lockout delay");
    acc(1'b1, 1'b1, 5'h0a, 8'h3c, 2, 0);
    i_host.access(1'b1, 1'b0, 5'h0a, 8'h00, 2);
    chk(d_oe === 1'b0 && reg_addr !== 5'h0a, "access in lockout");
    pf_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(locked === 1'b0, "lockout stuck");
    fork
      acc(1'b1, 1'b1, 5'h0c, 8'h81, LCYC + 6, 1);
      begin
        @(negedge clk);
        pf_n = 1'b0;
      end
    join
    chk(wdata === 8'h81 && reg_addr === 5'h0c, "write lost");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_port();
    t_irq();
    t_drive();
    t_gate();
    t_aux();
    t_lock();
    test_done();
  end
  initial begin
    #(3000 * 100);
    failures++;
    test_done();
  end
endmodule
